// ===== data_ram.sv
// Purpose: Byte-wide data memory with registered read data
// Assumes: One access per cycle, write wins nothing over read of a different address
// Notes: Read data appear one cycle after the address
module data_ram
  import exec_pkg::*;
(
  input  wire logic             aclk,
  input  wire exec_pkg::mem_req_s req,
  output logic [7:0]            rdata
);
  logic [7:0] mem [0:(1<<dmem_aw)-1];

  always_ff @(posedge aclk)
  begin
    if (req.we)
    begin
      mem[req.addr] <= req.wdata;
    end
    rdata <= mem[req.addr];
  end
endmodule : data_ram

// ===== exec_pkg.sv
// Purpose: Shared constants and types for the instruction execution subset
// Assumes: 40 MHz aclk, synchronous active-low reset, AXI4-Lite register access
// Notes: Register map, opcode order and state types shared by design and bench
package exec_pkg;

  // Register byte addresses
  localparam logic [7:0] ctrl_addr      = 8'h00;
  localparam logic [7:0] operand_addr   = 8'h04;
  localparam logic [7:0] wreg_addr      = 8'h08;
  localparam logic [7:0] flags_addr     = 8'h0c;
  localparam logic [7:0] result_addr    = 8'h10;
  localparam logic [7:0] table_ptr_addr = 8'h14;
  localparam logic [7:0] latch_addr     = 8'h18;
  localparam logic [7:0] status_addr    = 8'h1c;
  localparam logic [7:0] prog_addr      = 8'h20;

  // Control register fields
  localparam int op_lsb    = 0;
  localparam int bit_lsb   = 8;
  localparam int go_bit    = 11;
  localparam int ext_bit   = 12;
  localparam int bank_lsb  = 16;
  localparam int imm_lsb   = 24;

  // Flag register bit positions
  localparam int flag_c    = 0;
  localparam int flag_ac   = 1;
  localparam int flag_z    = 2;
  localparam int flag_ov   = 3;
  localparam int flag_sc   = 4;

  // Data memory shape: 8 sections of 256 bytes, program memory 256 words per page
  localparam int dmem_aw   = 11;
  localparam int pmem_aw   = 12;
  localparam logic [3:0] last_page = 4'hf;
  localparam logic [3:0] bcd_limit = 4'h9;
  localparam logic [3:0] bcd_fix   = 4'h6;
  localparam logic [31:0] reset_zero = 32'h0000_0000;
  localparam logic [1:0] resp_okay   = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;

  typedef enum logic [4:0] {
    op_skip_if_zero_byte,
    op_skip_zero_copy_to_wreg,
    op_skip_if_bit_zero,
    op_table_fetch_paged,
    op_table_fetch_last_page,
    op_preinc_table_fetch_paged,
    op_preinc_table_fetch_last_page,
    op_xor_to_wreg,
    op_exclusive_or_to_memory,
    op_xor_imm,
    op_far_add_carry,
    op_far_add_carry_to_memory,
    op_far_add,
    op_far_add_to_memory,
    op_far_and,
    op_far_and_to_memory,
    op_far_clear,
    op_far_clear_bit,
    op_far_invert,
    op_far_invert_to_wreg,
    op_far_decimal_adjust,
    op_far_decrement,
    op_far_decrement_to_wreg,
    op_far_increment,
    op_far_increment_to_wreg,
    op_far_move_to_wreg,
    op_far_move_to_mem,
    op_far_or,
    op_far_or_to_memory
  } opcode_e;

  typedef enum {
    st_idle,
    st_read,
    st_exec,
    st_dummy
  } exec_state_e;

  typedef struct packed {
    logic [4:0]  op;
    logic [2:0]  bit_sel;
    logic        extended;
    logic [2:0]  bank;
    logic [7:0]  operand;
    logic [7:0]  imm;
  } command_s;

  typedef struct packed {
    logic        we;
    logic [dmem_aw-1:0] addr;
    logic [7:0]  wdata;
  } mem_req_s;

endpackage : exec_pkg

// ===== instr_exec.sv
// Purpose: Executes the skip, table, exclusive-OR and far instruction subset
// Assumes: Software issues one instruction at a time through the register bus
// Notes: Program memory is a word table written by software over the bus
module instr_exec
  import exec_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             skip_next,
  output logic             busy
);
  import exec_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    exec_state_e state;
    command_s    cmd;
    logic [7:0]  working_register;
    logic [7:0]  flags;
    logic [7:0]  result;
    logic [7:0]  table_pointer_low;
    logic [7:0]  table_pointer_high;
    logic [7:0]  table_high_byte_latch;
    logic        skip_next;
    logic        busy;
    logic [7:0]  done_count;
    logic [pmem_aw-1:0] prog_waddr;
    logic        aw_held;
    logic [7:0]  aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } core_s;

  core_s r;
  core_s next_r;

  mem_req_s   dreq;
  logic [7:0] dbyte;
  logic [15:0] prog_mem [0:(1<<pmem_aw)-1];
  logic        prog_we;
  logic [15:0] prog_word;
  logic [pmem_aw-1:0] prog_raddr;

  data_ram u_data_ram
  (
    .aclk  (aclk),
    .req   (dreq),
    .rdata (dbyte)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Program memory, written over the bus, read asynchronously for table fetches

  always_ff @(posedge aclk)
  begin
    if (prog_we)
    begin
      prog_mem[r.prog_waddr] <= r.w_data[15:0];
    end
  end

  assign prog_word = prog_mem[prog_raddr];

  // Last-page forms ignore the high pointer; kept out of the main process so the
  // fetched word never feeds back into the logic that forms its own address
  assign prog_raddr = {((r.cmd.op == op_table_fetch_last_page || r.cmd.op == op_preinc_table_fetch_last_page)
                        ? last_page : r.table_pointer_high[3:0]), r.table_pointer_low};

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    logic [8:0]  sum;
    logic [4:0]  half;
    logic [7:0]  res;
    logic [7:0]  adj;
    logic        cin;
    logic        carry_hi;
    logic        wr_mem;
    logic        to_wreg;
    logic        set_z;
    logic        skip;
    logic        wr_ok;
    logic        rd_ok;
    logic [31:0] rd;
    sum      = '0;
    half     = '0;
    res      = '0;
    adj      = r.working_register;
    cin      = 1'b0;
    carry_hi = r.flags[flag_c];
    wr_mem   = 1'b0;
    to_wreg  = 1'b0;
    set_z    = 1'b0;
    skip     = 1'b0;
    wr_ok    = 1'b1;
    rd_ok    = 1'b1;
    rd       = '0;
    next_r   = r;
    prog_we  = 1'b0;
    // Extended forms address any section; ordinary ones stay in section 0
    dreq.we    = 1'b0;
    dreq.addr  = {(r.cmd.extended ? r.cmd.bank : 3'h0), r.cmd.operand};
    dreq.wdata = '0;

    // Bus write: address and data are taken independently, then answered
    next_r.awready = 1'b0;
    next_r.wready  = 1'b0;
    if (s_axi_awvalid && !r.aw_held && !r.awready)
    begin
      next_r.awready = 1'b1;
    end
    if (r.awready && s_axi_awvalid)
    begin
      next_r.aw_held = 1'b1;
      next_r.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !r.w_held && !r.wready)
    begin
      next_r.wready = 1'b1;
    end
    if (r.wready && s_axi_wvalid)
    begin
      next_r.w_held = 1'b1;
      next_r.w_data = s_axi_wdata;
      next_r.w_strb = s_axi_wstrb;
    end
    if (r.bvalid && s_axi_bready)
    begin
      next_r.bvalid = 1'b0;
    end
    if (r.aw_held && r.w_held && !r.bvalid)
    begin
      next_r.aw_held = 1'b0;
      next_r.w_held  = 1'b0;
      next_r.bvalid  = 1'b1;
      case (r.aw_addr)
        ctrl_addr:
        begin
          next_r.cmd.op       = r.w_data[op_lsb +: 5];
          next_r.cmd.bit_sel  = r.w_data[bit_lsb +: 3];
          next_r.cmd.extended = r.w_data[ext_bit];
          next_r.cmd.bank     = r.w_data[bank_lsb +: 3];
          next_r.cmd.imm      = r.w_data[imm_lsb +: 8];
          if (r.w_data[go_bit] && r.state == st_idle)
          begin
            next_r.state     = st_read;
            next_r.busy      = 1'b1;
            next_r.skip_next = 1'b0;
          end
        end
        operand_addr:   next_r.cmd.operand = r.w_data[7:0];
        wreg_addr:      next_r.working_register = r.w_data[7:0];
        flags_addr:     next_r.flags = r.w_data[7:0];
        table_ptr_addr:
        begin
          next_r.table_pointer_low  = r.w_data[7:0];
          next_r.table_pointer_high = r.w_data[15:8];
        end
        prog_addr:
        begin
          next_r.prog_waddr = r.w_data[16 +: pmem_aw];
          prog_we = 1'b1;
          next_r.prog_waddr = r.prog_waddr;
        end
        default: wr_ok = 1'b0;
      endcase
      if (r.aw_addr == prog_addr)
      begin
        next_r.prog_waddr = r.prog_waddr + 1'b1;
      end
      next_r.bresp = wr_ok ? resp_okay : resp_slverr;
    end

    // Bus read
    next_r.arready = 1'b0;
    if (r.rvalid && s_axi_rready)
    begin
      next_r.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !r.arready && !r.rvalid)
    begin
      next_r.arready = 1'b1;
    end
    // Answer only after the address handshake; the address still stands at that edge
    if (r.arready && s_axi_arvalid)
    begin
      case (s_axi_araddr)
        ctrl_addr:      rd = {r.cmd.imm, 5'h0, r.cmd.bank, 3'h0, r.cmd.extended, 1'b0, r.cmd.bit_sel, 3'h0, r.cmd.op};
        operand_addr:   rd = {24'h0, r.cmd.operand};
        wreg_addr:      rd = {24'h0, r.working_register};
        flags_addr:     rd = {24'h0, r.flags};
        result_addr:    rd = {24'h0, r.result};
        table_ptr_addr: rd = {16'h0, r.table_pointer_high, r.table_pointer_low};
        latch_addr:     rd = {24'h0, r.table_high_byte_latch};
        status_addr:    rd = {r.done_count, 22'h0, r.skip_next, r.busy};
        prog_addr:      rd = {4'h0, r.prog_waddr, 16'h0};
        default:        rd_ok = 1'b0;
      endcase
      next_r.rvalid = 1'b1;
      next_r.rdata  = rd;
      next_r.rresp  = rd_ok ? resp_okay : resp_slverr;
    end

    // Execution
    case (r.state)
      st_idle: ;
      st_read:
      begin
        // Pre-increment before the fetch so the fetch sees the new pointer
        if (r.cmd.op == op_preinc_table_fetch_paged || r.cmd.op == op_preinc_table_fetch_last_page)
        begin
          next_r.table_pointer_low = r.table_pointer_low + 8'h01;
        end
        next_r.state = st_exec;
      end
      st_exec:
      begin
        case (r.cmd.op)
          op_skip_if_zero_byte:
          begin
            res  = dbyte;
            skip = (dbyte == 8'h00);
          end
          op_skip_zero_copy_to_wreg:
          begin
            res = dbyte;
            to_wreg = 1'b1;
            skip = (dbyte == 8'h00);
          end
          op_skip_if_bit_zero:
          begin
            res  = dbyte;
            skip = !dbyte[r.cmd.bit_sel];
          end
          op_table_fetch_paged, op_preinc_table_fetch_paged,
          op_table_fetch_last_page, op_preinc_table_fetch_last_page:
          begin
            res = prog_word[7:0];
            wr_mem = 1'b1;
            next_r.table_high_byte_latch = prog_word[15:8];
          end
          op_xor_to_wreg, op_exclusive_or_to_memory, op_xor_imm:
          begin
            res = r.working_register ^ ((r.cmd.op == op_xor_imm) ? r.cmd.imm : dbyte);
            set_z = 1'b1;
            wr_mem = (r.cmd.op == op_exclusive_or_to_memory);
            to_wreg = !wr_mem;
          end
          op_far_add_carry, op_far_add_carry_to_memory, op_far_add, op_far_add_to_memory:
          begin
            cin  = (r.cmd.op == op_far_add_carry || r.cmd.op == op_far_add_carry_to_memory) && r.flags[flag_c];
            sum  = {1'b0, r.working_register} + {1'b0, dbyte} + {8'h0, cin};
            half = {1'b0, r.working_register[3:0]} + {1'b0, dbyte[3:0]} + {4'h0, cin};
            res  = sum[7:0];
            set_z = 1'b1;
            next_r.flags[flag_c]  = sum[8];
            next_r.flags[flag_ac] = half[4];
            next_r.flags[flag_ov] = (r.working_register[7] == dbyte[7]) && (res[7] != dbyte[7]);
            next_r.flags[flag_sc] = (r.working_register[7] == dbyte[7]) ? res[7] : sum[8] ^ 1'b1 ^ res[7] ^ res[7] ^ r.working_register[7] ^ dbyte[7] ^ 1'b1;
            wr_mem = (r.cmd.op == op_far_add_carry_to_memory || r.cmd.op == op_far_add_to_memory);
            to_wreg = !wr_mem;
          end
          op_far_and, op_far_and_to_memory, op_far_or, op_far_or_to_memory:
          begin
            res = (r.cmd.op == op_far_and || r.cmd.op == op_far_and_to_memory)
                ? (r.working_register & dbyte) : (r.working_register | dbyte);
            set_z = 1'b1;
            wr_mem = (r.cmd.op == op_far_and_to_memory || r.cmd.op == op_far_or_to_memory);
            to_wreg = !wr_mem;
          end
          op_far_clear:
          begin
            res = 8'h00;
            wr_mem = 1'b1;
          end
          op_far_clear_bit:
          begin
            res = dbyte;
            res[r.cmd.bit_sel] = 1'b0;
            wr_mem = 1'b1;
          end
          op_far_invert, op_far_invert_to_wreg:
          begin
            res = ~dbyte;
            set_z = 1'b1;
            wr_mem = (r.cmd.op == op_far_invert);
            to_wreg = !wr_mem;
          end
          op_far_decimal_adjust:
          begin
            if (adj[3:0] > bcd_limit || r.flags[flag_ac])
            begin
              adj = adj + {4'h0, bcd_fix};
            end
            carry_hi = r.flags[flag_c] || (r.working_register[7:4] > bcd_limit)
                     || (adj[3:0] < r.working_register[3:0] && r.working_register[7:4] == bcd_limit);
            sum = {1'b0, adj} + (carry_hi ? {1'b0, bcd_fix, 4'h0} : 9'h000);
            res = sum[7:0];
            next_r.flags[flag_c] = r.flags[flag_c] | sum[8] | (adj < r.working_register);
            wr_mem = 1'b1;
          end
          op_far_decrement, op_far_decrement_to_wreg:
          begin
            res = dbyte - 8'h01;
            set_z = 1'b1;
            wr_mem = (r.cmd.op == op_far_decrement);
            to_wreg = !wr_mem;
          end
          op_far_increment, op_far_increment_to_wreg:
          begin
            res = dbyte + 8'h01;
            set_z = 1'b1;
            wr_mem = (r.cmd.op == op_far_increment);
            to_wreg = !wr_mem;
          end
          op_far_move_to_wreg:
          begin
            res = dbyte;
            to_wreg = 1'b1;
          end
          op_far_move_to_mem:
          begin
            res = r.working_register;
            wr_mem = 1'b1;
          end
          default: ;
        endcase
        if (set_z)
        begin
          next_r.flags[flag_z] = (res == 8'h00);
        end
        if (to_wreg)
        begin
          next_r.working_register = res;
        end
        dreq.we    = wr_mem;
        dreq.wdata = res;
        next_r.result = res;
        next_r.skip_next = skip;
        // A taken skip spends one more cycle on the dummy instruction
        next_r.state = skip ? st_dummy : st_idle;
        next_r.busy  = skip;
        next_r.done_count = r.done_count + 8'h01;
      end
      st_dummy:
      begin
        next_r.state = st_idle;
        next_r.busy  = 1'b0;
      end
      default: next_r.state = st_idle;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r <= '0;
      r.state <= st_idle;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign s_axi_awready = r.awready;
  assign s_axi_wready  = r.wready;
  assign s_axi_bvalid  = r.bvalid;
  assign s_axi_bresp   = r.bresp;
  assign s_axi_arready = r.arready;
  assign s_axi_rvalid  = r.rvalid;
  assign s_axi_rdata   = r.rdata;
  assign s_axi_rresp   = r.rresp;
  assign skip_next     = r.skip_next;
  assign busy          = r.busy;
endmodule : instr_exec

// ===== instr_exec_bench.sv
// Purpose: Self-checking bench for instr_exec over AXI4-Lite
// Assumes: 40 MHz aclk, inputs driven by non-blocking assignment after edges
// Notes: Program memory is loaded up to the last page before table reads
module instr_exec_bench import exec_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // Row bytes: wreg, mem, imm, flags in, then expected wreg, mem, flags
  typedef struct packed {opcode_e op; logic [7:0] w, m, imm, f, ew, em, ef;} row_s;
  typedef struct packed {opcode_e op; logic [7:0] m; logic [2:0] bn; logic sk;} skip_s;
  typedef struct packed {opcode_e op; logic [15:0] p; logic [7:0] em, el; logic [15:0] ep;} tab_s;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, skip_next, busy;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, wresp, rsp;
  logic [2:0]  b;
  int          errors, checks_done, cycles, busy_cycles, base, d;
  row_s  rows [24] = '{
    {op_xor_to_wreg, 56'h5a5a0000005a04}, {op_exclusive_or_to_memory, 56'h0ff000040fff00},
    {op_xor_imm, 56'h33113301001105}, {op_far_add_carry, 56'h0f010001110102},
    {op_far_add_carry_to_memory, 56'hff010001ff0103}, {op_far_add, 56'hf0f00001e0f011},
    {op_far_add_to_memory, 56'h00000000000004}, {op_far_and, 56'hf00f0000000f04},
    {op_far_and_to_memory, 56'h3cf000043c3000}, {op_far_clear, 56'h00a50000000000},
    {op_far_clear_bit, 56'h00ff000000df00}, {op_far_invert, 56'h12ff0000120004},
    {op_far_invert_to_wreg, 56'h000f0004f00f00}, {op_far_decimal_adjust, 56'ha5000000a50501},
    {op_far_decimal_adjust, 56'h12000002121802}, {op_far_decrement, 56'h00010000000004},
    {op_far_decrement_to_wreg, 56'h00000004ff0000}, {op_far_increment, 56'h00ff0000000004},
    {op_far_increment_to_wreg, 56'h00410004424100}, {op_far_move_to_wreg, 56'h55000000000000},
    {op_far_or, 56'h00000000000004}, {op_far_or_to_memory, 56'ha0050004a0a500},
    {op_skip_zero_copy_to_wreg, 56'h77000000000000}, {op_far_move_to_mem, 56'h3c0000043c3c04}};
  skip_s skips [7] = '{{op_skip_if_zero_byte, 8'h01, 3'd0, 1'b0}, {op_skip_if_zero_byte, 8'h00, 3'd0, 1'b1},
    {op_skip_zero_copy_to_wreg, 8'h00, 3'd0, 1'b1}, {op_skip_zero_copy_to_wreg, 8'h80, 3'd0, 1'b0},
    {op_skip_if_bit_zero, 8'hf7, 3'd3, 1'b1}, {op_skip_if_bit_zero, 8'h08, 3'd3, 1'b0},
    {op_skip_if_bit_zero, 8'h7f, 3'd7, 1'b1}};
  // Pointer wrap from 0xff shows the pre-increment touches the low byte only
  tab_s  tabs [4] = '{{op_table_fetch_paged, 16'h0205, 8'h05, 8'ha2, 16'h0205},
    {op_table_fetch_last_page, 16'h0201, 8'h01, 8'haf, 16'h0201},
    {op_preinc_table_fetch_paged, 16'h01ff, 8'h00, 8'ha1, 16'h0100},
    {op_preinc_table_fetch_last_page, 16'h0000, 8'h01, 8'haf, 16'h0001}};
  logic [7:0] zero_regs [4] = '{wreg_addr, flags_addr, latch_addr, table_ptr_addr};

  instr_exec DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .skip_next(skip_next), .busy(busy));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  // Bready stays up from the start, so the answer is taken at the edge it shows
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    wresp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rdreg(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rdreg

  task automatic run(input opcode_e op, input logic [2:0] bk, input logic [7:0] a, input logic [7:0] imm,
                     input logic [2:0] bn);
    int   n;
    logic ext;
    n = busy_cycles;
    ext = (op >= op_far_add_carry);
    wr(operand_addr, {24'h0, a});
    wr(ctrl_addr, {imm, 5'h0, bk, 3'h0, ext, 1'b1, bn, 3'h0, op});
    repeat (2) @(posedge aclk);
    while (busy !== 1'b0) @(posedge aclk);
    d = busy_cycles - n;
  endtask : run

  task automatic poke(input logic [2:0] bk, input logic [7:0] a, input logic [7:0] v);
    wr(wreg_addr, {24'h0, v});
    run(op_far_move_to_mem, bk, a, 8'h00, 3'h0);
  endtask : poke

  task automatic peek(input logic [2:0] bk, input logic [7:0] a);
    run(op_far_move_to_wreg, bk, a, 8'h00, 3'h0);
    rdreg(wreg_addr);
  endtask : peek

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // Hang guard: the program load dominates at roughly 19k cycles
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (busy === 1'b1) busy_cycles <= busy_cycles + 1;
    if (cycles == 80000)
    begin
      errors++;
      give_verdict;
    end
  end

  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (zero_regs[i])
    begin
      rdreg(zero_regs[i]);
      check(rd, reset_zero);
    end
    rdreg(8'h40);
    check({30'h0, rsp}, {30'h0, resp_slverr});
    wr(8'h44, 32'h1);
    check({30'h0, wresp}, {30'h0, resp_slverr});
    for (int a = 0; a <= 'hf01; a++)
      wr(prog_addr, {16'h0, 4'ha, 12'(a)});
    foreach (rows[i])
    begin
      b = (rows[i].op >= op_far_add_carry) ? 3'(i) : 3'h0;
      poke(b, 8'h40 + 8'(i), rows[i].m);
      wr(wreg_addr, {24'h0, rows[i].w});
      wr(flags_addr, {24'h0, rows[i].f});
      run(rows[i].op, b, 8'h40 + 8'(i), rows[i].imm, 3'd5);
      rdreg(wreg_addr);
      check(rd, {24'h0, rows[i].ew});
      rdreg(flags_addr);
      check(rd, {24'h0, rows[i].ef});
      peek(b, 8'h40 + 8'(i));
      check(rd, {24'h0, rows[i].em});
    end
    // Same offset in two sections must stay apart
    poke(3'd2, 8'h10, 8'h22);
    poke(3'd6, 8'h10, 8'h66);
    peek(3'd2, 8'h10);
    check(rd, 32'h22);
    // An ordinary form ignores the bank field and stays in section 0
    poke(3'd0, 8'h10, 8'h0f);
    wr(wreg_addr, 32'h0);
    run(op_xor_to_wreg, 3'd6, 8'h10, 8'h00, 3'h0);
    rdreg(wreg_addr);
    check(rd, 32'h0f);
    foreach (skips[i])
    begin
      poke(3'h0, 8'h60 + 8'(i), skips[i].m);
      wr(flags_addr, 32'h1f);
      run(skips[i].op, 3'h0, 8'h60 + 8'(i), 8'h00, skips[i].bn);
      if (i == 0) base = d;
      check({31'h0, skip_next}, {31'h0, skips[i].sk});
      check(d, base + skips[i].sk);
      rdreg(flags_addr);
      check(rd, 32'h1f);
      peek(3'h0, 8'h60 + 8'(i));
      check(rd, {24'h0, skips[i].m});
    end
    foreach (tabs[i])
    begin
      wr(table_ptr_addr, {16'h0, tabs[i].p});
      run(tabs[i].op, 3'h0, 8'h70, 8'h00, 3'h0);
      peek(3'h0, 8'h70);
      check(rd, {24'h0, tabs[i].em});
      rdreg(latch_addr);
      check(rd, {24'h0, tabs[i].el});
      rdreg(table_ptr_addr);
      check(rd, {16'h0, tabs[i].ep});
    end
    // A second reset in mid-run must clear the working state again
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (zero_regs[i])
    begin
      rdreg(zero_regs[i]);
      check(rd, reset_zero);
    end
    give_verdict;
  end
endmodule : instr_exec_bench

// ===== instr_exec_chk.sv
// Purpose: Port-level timing checks for instr_exec
// Assumes: Single aclk domain, aresetn synchronous and active low
// Notes: Bound to every instr_exec at the foot of this file
module instr_exec_chk
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        skip_next,
  input wire logic        busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_busy_min_two: assert property ($rose(busy) |=> busy)
    else $error("instruction finished after one cycle");
  a_busy_max_three: assert property ($rose(busy) |-> ##[2:3] !busy)
    else $error("instruction ran longer than three cycles");
  a_skip_long_run: assert property ($fell(busy) && $past(busy, 3) |-> ##[0:1] skip_next)
    else $error("three-cycle instruction without a taken skip");
  a_plain_short_run: assert property ($fell(busy) && !$past(busy, 3) |-> !skip_next)
    else $error("taken skip without the dummy cycle");
  a_skip_flag_quiet: assert property ($changed(skip_next) |-> (busy || $past(busy)) or (##1 busy))
    else $error("skip flag moved outside an instruction");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid)
    else $error("write answer late");
  a_rvalid_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data held after handshake");
  a_bvalid_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response held after handshake");
endmodule : instr_exec_chk

bind instr_exec instr_exec_chk chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .skip_next(skip_next), .busy(busy));
